// ---- pkg/ast_pkg.sv ----
package ast_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'h13;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h14;
  localparam logic [7:0] IDX_CTRL_THREE = 8'h15;
  localparam logic [7:0] IDX_STATUS_ONE = 8'h16;
  localparam logic [7:0] IDX_DATA_BUF = 8'h18;
  localparam logic [7:0] IDX_BAUD_SEL = 8'h19;
  localparam int ADDR_W = 8;

  // control one fields
  localparam int C1_LOOP = 7;
  localparam int C1_MODULE_ON = 6;
  localparam int C1_POL_FLIP = 5;
  localparam int C1_CHAR_LEN = 4;
  // control two fields
  localparam int C2_EMPTY_IRQ_ON = 7;
  localparam int C2_DONE_IRQ_ON = 6;
  localparam int C2_TX_ON = 3;
  // control three fields
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  localparam int C3_DMA_REQ_ON = 4;
  // status one fields
  localparam int S1_EMPTY = 7;
  localparam int S1_DONE = 6;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // bit clock: divisor = (baud_select + 1) * BAUD_UNIT module clocks
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_UNIT = 16;
  localparam int DIV_W = 13;
  localparam logic [DIV_W-1:0] BAUD_UNIT_CNT = DIV_W'(BAUD_UNIT);

  // frame: start, up to nine data bits, stop
  localparam int FRAME_W = 11;
  localparam logic [3:0] FRAME_LEN_8 = 4'hA;
  localparam logic [3:0] FRAME_LEN_9 = 4'hB;

  typedef enum logic [2:0] {
    AST_IDLE = 3'b001,
    AST_PREAMBLE = 3'b010,
    AST_SHIFT = 3'b100
  } ast_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [7:0] writedata;
  } ast_bus_req_t;

  typedef struct packed {
    logic tx_irq;
    logic tx_dma_req;
  } ast_req_out_t;

endpackage

// ---- rtl/ast_transmitter.sv ----
// Operation
// - shifter drives pin, one bit per bit time
// - write-only data buffer feeds the shifter
// - status read then data write clears empty
// - transmission opens with all-ones preamble
// - after preamble, buffer moves into shifter
// - start bit low LSB, stop high MSB
// - empty flag sets on buffer-to-shifter transfer
// - empty plus irq on, no dma: interrupt
// - dma on routes empty to dma request
// - idle shifter drives pin high
// - module off releases the port pin
// - control two bit layout
// - control three bit layout
// - status one bit layout
// - control one bit layout
// - nine-bit mode sends ninth bit as bit 8
// - polarity flip inverts every pin level
// - done flag when shifter and buffer empty
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module ast_transmitter
  import ast_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire ast_bus_req_t avs_req,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  // service requests
  output ast_req_out_t req_out,
  // serial pin and port ownership
  output logic txd_out,
  output logic txd_oe
);

  // registers
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] ctrl_three_reg;
  logic [7:0] baud_sel_reg;
  logic [7:0] data_buf_reg;
  logic [7:0] readdata_reg;
  logic buf_full_reg;
  logic empty_flag_reg;
  logic empty_armed_reg;
  logic ack_reg;
  logic tx_on_prev_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic [FRAME_W-1:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  ast_state_t state_reg;

  // next values
  logic [FRAME_W-1:0] shift_next;
  logic [3:0] bit_cnt_next;
  ast_state_t state_next;
  logic transfer;

  // bus decode
  wire logic req_any = avs_req.read | avs_req.write;
  wire logic access = req_any & ack_reg;
  wire logic wr = access & avs_req.write;
  wire logic rd = access & avs_req.read;
  wire logic word_ok = avs_req.address[1:0] == 2'b00;
  wire logic [ADDR_W-1:0] idx = {2'b00, avs_req.address[ADDR_W-1:2]};
  wire logic hit_c1 = word_ok & (idx == IDX_CTRL_ONE);
  wire logic hit_c2 = word_ok & (idx == IDX_CTRL_TWO);
  wire logic hit_c3 = word_ok & (idx == IDX_CTRL_THREE);
  wire logic hit_s1 = word_ok & (idx == IDX_STATUS_ONE);
  wire logic hit_db = word_ok & (idx == IDX_DATA_BUF);
  wire logic hit_bs = word_ok & (idx == IDX_BAUD_SEL);

  // control bits
  wire logic module_on_bit = ctrl_one_reg[C1_MODULE_ON];
  wire logic tx_polarity_flip = ctrl_one_reg[C1_POL_FLIP];
  wire logic nine_bit_mode = ctrl_one_reg[C1_CHAR_LEN];
  wire logic tx_empty_irq_on = ctrl_two_reg[C2_EMPTY_IRQ_ON];
  wire logic tx_done_irq_on = ctrl_two_reg[C2_DONE_IRQ_ON];
  wire logic tx_on_bit = ctrl_two_reg[C2_TX_ON];
  wire logic tx_ninth_bit = ctrl_three_reg[C3_TX_NINTH];
  wire logic tx_dma_request_on = ctrl_three_reg[C3_DMA_REQ_ON];
  // new frames start only with both enables
  wire logic tx_active = module_on_bit & tx_on_bit;
  wire logic tx_on_rise = tx_active & ~tx_on_prev_reg;

  // bit clock divider
  wire logic [DIV_W-1:0] div_top =
    DIV_W'((baud_sel_reg + 9'h001) * BAUD_UNIT_CNT) - DIV_W'(1);
  wire logic bit_tick = (div_cnt_reg == div_top);

  // start low in LSB, stop high in MSB
  // ninth bit fills bit 8 in nine-bit mode
  wire logic [FRAME_W-1:0] frame_8 = {2'b11, data_buf_reg, 1'b0};
  wire logic [FRAME_W-1:0] frame_9 =
    {1'b1, tx_ninth_bit, data_buf_reg, 1'b0};
  wire logic [FRAME_W-1:0] frame_load = nine_bit_mode ? frame_9 : frame_8;
  wire logic [3:0] frame_len = nine_bit_mode ? FRAME_LEN_9 : FRAME_LEN_8;
  wire logic last_bit = bit_tick & (bit_cnt_reg == 4'h1);

  // nothing in shifter and nothing buffered
  wire logic tx_done_flag = (state_reg == AST_IDLE) & ~buf_full_reg;
  wire logic tx_buffer_empty_flag = empty_flag_reg;

  // status one layout, receive flags read zero
  wire logic [7:0] status_one =
    {tx_buffer_empty_flag, tx_done_flag, 6'h00};
  // received ninth bit not built, reads zero
  wire logic [7:0] ctrl_three_view = {1'b0, ctrl_three_reg[6:0]};

  // data buffer is write-only, reads zero
  wire logic [7:0] read_mux =
    hit_c1 ? ctrl_one_reg :
    hit_c2 ? ctrl_two_reg :
    hit_c3 ? ctrl_three_view :
    hit_s1 ? status_one :
    hit_bs ? baud_sel_reg : 8'h00;

  // one wait cycle per access keeps the decode off the read path
  assign avs_waitrequest = req_any & ~ack_reg;
  assign avs_readdata = readdata_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      readdata_reg <= 8'h00;
    end else begin
      ack_reg <= req_any & ~ack_reg;
      if (req_any & ~ack_reg) begin
        readdata_reg <= read_mux;
      end
    end
  end

  // control one write, full byte stored
  // control two write, full byte stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_one_reg <= RST_CTRL;
      ctrl_two_reg <= RST_CTRL;
      ctrl_three_reg <= RST_CTRL;
      baud_sel_reg <= RST_BAUD;
    end else begin
      if (wr & hit_c1) begin
        ctrl_one_reg <= avs_req.writedata;
      end
      if (wr & hit_c2) begin
        ctrl_two_reg <= avs_req.writedata;
      end
      if (wr & hit_c3) begin
        ctrl_three_reg <= avs_req.writedata;
      end
      if (wr & hit_bs) begin
        baud_sel_reg <= avs_req.writedata;
      end
    end
  end

  // data buffer writes land in the holding buffer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_buf_reg <= RST_DATA;
      buf_full_reg <= 1'b0;
    end else begin
      if (wr & hit_db) begin
        data_buf_reg <= avs_req.writedata;
      end
      if (wr & hit_db) begin
        buf_full_reg <= 1'b1;
      end else if (transfer) begin
        buf_full_reg <= 1'b0;
      end
    end
  end

  // read of status arms, data write clears
  // transfer sets the flag and wins over a clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      empty_flag_reg <= 1'b1;
      empty_armed_reg <= 1'b0;
    end else begin
      if (transfer) begin
        empty_flag_reg <= 1'b1;
      end else if (wr & hit_db & empty_armed_reg) begin
        empty_flag_reg <= 1'b0;
      end
      if (rd & hit_s1 & empty_flag_reg) begin
        empty_armed_reg <= 1'b1;
      end else if (wr & hit_db) begin
        empty_armed_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= '0;
    end else if (!module_on_bit || state_reg == AST_IDLE) begin
      div_cnt_reg <= '0;
    end else if (bit_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    transfer = 1'b0;
    case (state_reg)
      AST_IDLE: begin
        if (tx_on_rise) begin
          // preamble of ones opens the transmission
          state_next = AST_PREAMBLE;
          shift_next = '1;
          bit_cnt_next = frame_len;
        end else if (tx_active & buf_full_reg) begin
          state_next = AST_SHIFT;
          shift_next = frame_load;
          bit_cnt_next = frame_len;
          transfer = 1'b1;
        end
      end
      AST_PREAMBLE, AST_SHIFT: begin
        if (bit_tick) begin
          shift_next = {1'b1, shift_reg[FRAME_W-1:1]};
          bit_cnt_next = bit_cnt_reg - 4'h1;
        end
        if (last_bit) begin
          if (tx_active & buf_full_reg) begin
            // buffer moves in once the shifter drains
            state_next = AST_SHIFT;
            shift_next = frame_load;
            bit_cnt_next = frame_len;
            transfer = 1'b1;
          end else begin
            state_next = AST_IDLE;
          end
        end
      end
      default: begin
        state_next = AST_IDLE;
      end
    endcase
  end

  // module off abandons the frame at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= AST_IDLE;
      shift_reg <= '1;
      bit_cnt_reg <= 4'h0;
      tx_on_prev_reg <= 1'b0;
    end else if (!module_on_bit) begin
      state_reg <= AST_IDLE;
      shift_reg <= '1;
      bit_cnt_reg <= 4'h0;
      tx_on_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      tx_on_prev_reg <= tx_active;
    end
  end

  // idle shifter holds the line high
  wire logic line_level = (state_reg == AST_IDLE) ? 1'b1 : shift_reg[0];
  logic txd_out_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txd_out_reg <= 1'b1;
    end else begin
      // polarity flip covers idle and framing bits
      txd_out_reg <= line_level ^ tx_polarity_flip;
    end
  end
  assign txd_out = txd_out_reg;
  // port released while the module is off
  assign txd_oe = module_on_bit;

  // empty flag interrupts unless dma owns it
  // dma on steers empty flag to dma request
  assign req_out.tx_irq =
    (tx_buffer_empty_flag & tx_empty_irq_on & ~tx_dma_request_on) |
    (tx_done_flag & tx_done_irq_on & module_on_bit);
  assign req_out.tx_dma_req =
    tx_buffer_empty_flag & tx_empty_irq_on & tx_dma_request_on;

endmodule // ast_transmitter

`default_nettype wire

// ---- testbench/ast_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module ast_asserts
  import ast_pkg::*;
#(parameter int BT = 16)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register bus
  input wire ast_bus_req_t avs_req,
  input wire logic [7:0] avs_readdata,
  input wire logic avs_waitrequest,
  // requests and pin
  input wire ast_req_out_t req_out,
  input wire logic txd_out,
  input wire logic txd_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic prev_q;
  logic [7:0] run_q;
  wire logic [7:0] a = avs_req.address;
  wire logic rd_ok = avs_req.read && !avs_waitrequest;
  wire logic mapped = a == 8'h4C || a == 8'h50 || a == 8'h54 ||
    a == 8'h58 || a == 8'h60 || a == 8'h64;
  // cycles since the pin last moved, saturating
  always_ff @(posedge sys_clk) begin
    prev_q <= txd_out;
    if (!rst_n) run_q <= 8'hFF;
    else if (txd_out != prev_q) run_q <= 8'h00;
    else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
  end
  property p_wait;
    $rose(avs_req.read || avs_req.write) |->
      avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait cycle count wrong");
  property p_nowait;
    !(avs_req.read || avs_req.write) |-> !avs_waitrequest;
  endproperty
  a_nowait: assert property (p_nowait)
    else $error("waitrequest without request");
  property p_unmap;
    rd_ok && !mapped |-> avs_readdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_dbuf;
    rd_ok && a == 8'h60 |-> avs_readdata == 8'h00;
  endproperty
  a_dbuf: assert property (p_dbuf)
    else $error("data buffer readable");
  property p_stat;
    rd_ok && a == 8'h58 |-> avs_readdata[5:0] == 6'h00;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status low bits set");
  property p_c3;
    rd_ok && a == 8'h54 |-> !avs_readdata[7];
  endproperty
  a_c3: assert property (p_c3)
    else $error("control three bit 7 set");
  property p_rst;
    $rose(rst_n) |-> txd_out && !txd_oe && req_out == 2'b00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset outputs wrong");
  property p_idle;
    (!txd_oe && !avs_req.write) [*3] |=> $stable(txd_out);
  endproperty
  a_idle: assert property (p_idle)
    else $error("released pin moved");
  property p_bit;
    $changed(txd_out) && txd_oe |-> run_q >= 8'(BT - 1);
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit shorter than bit time");
  c_frame: cover property ($fell(txd_out) && txd_oe);
  c_irq: cover property (req_out.tx_irq);
  c_dma: cover property (req_out.tx_dma_req);
endmodule // ast_asserts
bind ast_transmitter ast_asserts #(.BT(16)) i_ast_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .req_out(req_out), .txd_out(txd_out), .txd_oe(txd_oe));
`default_nettype wire

// ---- testbench/ast_rx_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ast_rx_model #(parameter int BT = 16) (
  // clock
  input wire logic sys_clk,
  // line and setup
  input wire logic rxd,
  input wire logic inv,
  input wire logic nine,
  input wire logic en,
  // received character
  output logic [8:0] data,
  output logic bad,
  output int got
);
  initial begin
    data = 9'h000;
    bad = 1'b0;
    got = 0;
    forever begin
      @(posedge sys_clk);
      if (en && (rxd ^ inv) == 1'b0) begin
        repeat (BT / 2) @(posedge sys_clk);
        bad = rxd ^ inv;
        for (int i = 0; i < 9; i++) begin
          if (i < 8 || nine) begin
            repeat (BT) @(posedge sys_clk);
            data[i] = rxd ^ inv;
          end
        end
        if (!nine) data[8] = 1'b0;
        repeat (BT) @(posedge sys_clk);
        bad = bad | !(rxd ^ inv);
        got = got + 1;
      end
    end
  end
endmodule // ast_rx_model
`default_nettype wire

// ---- testbench/ast_transmitter_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module ast_transmitter_bench;
  import ast_pkg::*;
  logic sys_clk, rst_n, txd, oe, inv, nine, en, rx_bad;
  logic [7:0] rdata, junk;
  logic [8:0] rx_data;
  logic wreq;
  ast_bus_req_t req;
  ast_req_out_t rout;
  int rx_got, fails, compares, n, g;
  ast_transmitter i_ast_transmitter (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .req_out(rout), .txd_out(txd), .txd_oe(oe));
  // a released line idles high on its pull-up
  ast_rx_model #(.BT(16)) i_ast_rx_model (.sys_clk(sys_clk),
    .rxd(oe ? txd : 1'b1),
    .inv(inv), .nine(nine), .en(en), .data(rx_data), .bad(rx_bad),
    .got(rx_got));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one request, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] ad, wd,
    output logic [7:0] rd);
    int k;
    k = 0;
    req <= '{read: !wr, write: wr, address: ad, writedata: wd};
    @(posedge sys_clk);
    while (wreq !== 1'b0) begin
      k++;
      if (k > 20) begin
        fails++;
        end_sim();
      end
      @(posedge sys_clk);
    end
    rd = rdata;
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic w(input logic [7:0] ad, d);
    bus(1'b1, ad, d, junk);
  endtask
  task automatic rc(input string nm, input logic [7:0] ad, e);
    bus(1'b0, ad, 8'h00, junk);
    chk(nm, junk, e);
  endtask
  // a status read that sees empty set arms the clear
  task automatic send(input logic [7:0] d);
    bus(1'b0, 8'h58, 8'h00, junk);
    w(8'h60, d);
  endtask
  task automatic wait_got(input int c);
    int k;
    k = 0;
    while (rx_got < c) begin
      k++;
      if (k > 600) begin
        fails++;
        end_sim();
      end
      @(posedge sys_clk);
    end
    chk("stop", rx_bad, 9'h000);
  endtask
  task automatic t_regs();
    logic [7:0] ads [6] = '{8'h4C, 8'h50, 8'h54, 8'h64, 8'h70, 8'h4D};
    foreach (ads[i]) rc("reg", ads[i], RST_CTRL);
    rc("status", 8'h58, 8'hC0);
    rc("dbuf", 8'h60, 8'h00);
    w(8'h54, 8'hFF);
    rc("ctrl3", 8'h54, 8'h7F);
    w(8'h64, 8'h5A);
    rc("baud", 8'h64, 8'h5A);
    w(8'h54, 8'h00);
    w(8'h64, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_frame();
    w(8'h4C, 8'h40);
    rc("st_full", 8'h58, 8'hC0);
    w(8'h60, 8'hA5);
    rc("st_clr", 8'h58, 8'h00);
    g = rx_got;
    w(8'h50, 8'h08);
    n = 0;
    while (txd !== 1'b0 && n < 400) begin
      n++;
      @(posedge sys_clk);
    end
    chk("preamble", n >= 158 && n <= 164, 9'h001);
    rc("st_busy", 8'h58, 8'h80);
    wait_got(g + 1);
    chk("byte", rx_data, 9'h0A5);
    $display("t_frame done");
  endtask
  task automatic t_back();
    w(8'h4C, 8'h50);
    w(8'h54, 8'h40);
    nine <= 1'b1;
    g = rx_got;
    send(8'h3C);
    rc("st_a", 8'h58, 8'h80);
    w(8'h60, 8'hC3);
    rc("st_b", 8'h58, 8'h00);
    wait_got(g + 1);
    chk("nine_a", rx_data, 9'h13C);
    wait_got(g + 2);
    chk("nine_b", rx_data, 9'h1C3);
    w(8'h4C, 8'h40);
    w(8'h54, 8'h00);
    nine <= 1'b0;
    $display("t_back done");
  endtask
  task automatic t_irq();
    w(8'h50, 8'h88);
    chk("irq", {rout.tx_irq, rout.tx_dma_req}, 9'h002);
    w(8'h54, 8'h10);
    chk("dma", {rout.tx_irq, rout.tx_dma_req}, 9'h001);
    w(8'h50, 8'hC8);
    chk("done_irq", {rout.tx_irq, rout.tx_dma_req}, 9'h003);
    w(8'h50, 8'h88);
    g = rx_got;
    send(8'h55);
    send(8'h66);
    chk("dma_clr", {rout.tx_irq, rout.tx_dma_req}, 9'h000);
    wait_got(g + 2);
    chk("byte2", rx_data, 9'h066);
    chk("dma_set", rout.tx_dma_req, 9'h001);
    w(8'h54, 8'h00);
    w(8'h50, 8'h08);
    $display("t_irq done");
  endtask
  task automatic t_off();
    send(8'h81);
    repeat (40) @(posedge sys_clk);
    w(8'h4C, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("release", {oe, txd}, 9'h001);
    // let the receiver drain the cut-off frame
    repeat (200) @(posedge sys_clk);
    g = rx_got;
    en <= 1'b0;
    w(8'h4C, 8'h60);
    inv <= 1'b1;
    repeat (2) @(posedge sys_clk);
    en <= 1'b1;
    chk("idle_inv", txd, 9'h000);
    send(8'h5A);
    wait_got(g + 1);
    chk("byte_inv", rx_data, 9'h05A);
    $display("t_off done");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    inv = 1'b0;
    nine = 1'b0;
    en = 1'b1;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_frame();
    t_back();
    t_irq();
    t_off();
    end_sim();
  end
endmodule // ast_transmitter_bench
`default_nettype wire
